// ---- common/srp_pkg.sv ----
/*
 Shared constants for the serial remote port: framing, character codes,
 rate selection, terminator encodings and queue thresholds.
 Assumes a 40 MHz system clock.
*/
package srp_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned OVERSAMPLE = 16;
	// Rate select codes
	localparam logic [2:0] RATE_19200 = 3'h0;
	localparam logic [2:0] RATE_9600 = 3'h1;
	localparam logic [2:0] RATE_4800 = 3'h2;
	localparam logic [2:0] RATE_2400 = 3'h3;
	localparam logic [2:0] RATE_1200 = 3'h4;
	localparam logic [2:0] RATE_600 = 3'h5;
	localparam logic [2:0] RATE_300 = 3'h6;
	localparam logic [2:0] RATE_RESET = RATE_9600;
	localparam int unsigned BAUD_MAX = 19200;
	localparam int unsigned BAUD_DEFAULT = 9600;
	// Oversample tick divisor at the fastest rate, rounded down
	localparam int unsigned TICK_DIV_BASE = CLK_HZ / (BAUD_MAX * OVERSAMPLE);
	localparam int unsigned TICK_CNT_W = 16;
	// Terminator select codes
	localparam logic [1:0] TERM_LF = 2'h0;
	localparam logic [1:0] TERM_CR = 2'h1;
	localparam logic [1:0] TERM_CRLF = 2'h2;
	localparam logic [1:0] TERM_LFCR = 2'h3;
	// Character codes
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_XON = 8'h11;
	localparam logic [7:0] CH_XOFF = 8'h13;
	localparam logic [7:0] CH_CTRL_C = 8'h03;
	localparam logic [7:0] CH_CTRL_X = 8'h18;
	// Receive queue
	localparam int unsigned RXQ_DEPTH = 16;
	localparam int unsigned RXQ_AW = 4;
	localparam logic [RXQ_AW:0] RXQ_HIGH = 5'(RXQ_DEPTH * 3 / 4);
	localparam logic [RXQ_AW:0] RXQ_LOW = 5'(RXQ_DEPTH / 2);
	localparam logic COMMAND_LANGUAGE_SETTING_STANDARD = 1'b0;
endpackage

// ---- rtl/srp_buf2.sv ----
/*
 Two-entry valid/ready buffer for byte data.
 Assumes one clock; the drain side may stall at any time.
*/
`timescale 1ns/100ps
`default_nettype none
module srp_buf2 #(
	parameter int unsigned W = 8
) (
	input wire logic clk_i, // System clock
	input wire logic reset_i, // Async reset, high
	input wire logic flush_i, // Drop all entries
	input wire logic [W-1:0] in_data_i, // Fill data
	input wire logic in_valid_i, // Fill valid
	output logic in_ready_o, // Room available
	output logic [W-1:0] out_data_o, // Head data
	output logic out_valid_o, // Head valid
	input wire logic out_ready_i // Drain accepts
);
	logic [W-1:0] mem_ff [2];
	logic [W-1:0] nxt_mem [2];
	logic rd_ff, nxt_rd, wr_ff, nxt_wr;
	logic [1:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign in_ready_o = (cnt_ff != 2'h2);
	assign out_valid_o = (cnt_ff != 2'h0);
	assign out_data_o = mem_ff[rd_ff];

	always_comb
	begin
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		nxt_mem = mem_ff;
		nxt_rd = rd_ff;
		nxt_wr = wr_ff;
		nxt_cnt = cnt_ff;
		if (flush_i)
		begin
			nxt_rd = 1'b0;
			nxt_wr = 1'b0;
			nxt_cnt = 2'h0;
		end
		else
		begin
			if (push)
			begin
				nxt_mem[wr_ff] = in_data_i;
				nxt_wr = ~wr_ff;
			end
			if (pop)
				nxt_rd = ~rd_ff;
			nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
		end
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end
		else
		begin
			mem_ff <= nxt_mem;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/srp_top.sv ----
/*
 Serial remote port: 8N1 receiver and transmitter, rate select, software
 pause/resume flow control, receive queue with line release on carriage
 return, break handling and message terminators.
 Assumes inputs synchronous to clk_i and a host keeping the same rate.
*/
`timescale 1ns/100ps
`default_nettype none
module srp_top
	import srp_pkg::*;
#(
	parameter int unsigned RX_DEPTH = srp_pkg::RXQ_DEPTH
) (
	input wire logic clk_i, // System clock
	input wire logic reset_i, // Async reset, high
	input wire logic rxd_i, // Serial receive line
	output logic txd_o, // Serial transmit line
	input wire logic [2:0] rate_sel_i, // Rate code
	input wire logic rate_load_i, // Load rate code
	input wire logic software_flow_option_i, // Pause/resume enable
	input wire logic [1:0] term_sel_i, // Terminator code
	input wire logic command_language_setting_i, // Stored language
	input wire logic [7:0] msg_data_i, // Outgoing message byte
	input wire logic msg_last_i, // Last byte of message
	input wire logic msg_valid_i, // Outgoing byte valid
	output logic msg_ready_o, // Outgoing byte taken
	output logic [7:0] cmd_data_o, // Command byte to parser
	output logic cmd_valid_o, // Command byte valid
	input wire logic cmd_ready_i, // Parser takes byte
	output logic cmd_line_o, // Complete line waiting
	output logic abort_o, // Break seen, pulse
	output logic command_language_setting_reject_o, // Serial language illegal
	output logic paused_o, // Host asked us to pause
	output logic rx_overrun_o, // Byte lost, queue full
	output logic [2:0] rate_o // Active rate code
);
	// ----------------------------------------
	// Rate generation
	// ----------------------------------------
	logic [2:0] rate_ff, nxt_rate;
	logic [TICK_CNT_W-1:0] tdiv_ff, nxt_tdiv;
	logic tick;
	logic [TICK_CNT_W-1:0] div_lim;

	always_comb
	begin
		nxt_rate = rate_load_i && rate_sel_i <= RATE_300 ? rate_sel_i : rate_ff;
		div_lim = TICK_CNT_W'((TICK_DIV_BASE << rate_ff) - 1);
		// Compare high side: a rate change may leave the count past the limit
		tick = (tdiv_ff >= div_lim);
		nxt_tdiv = tick ? '0 : TICK_CNT_W'(tdiv_ff + 1'b1);
	end

	// ----------------------------------------
	// Receiver, 16x oversampled
	// ----------------------------------------
	typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_DATA = 3'b010,
		RX_STOP = 3'b100} srp_rx_e;
	srp_rx_e rxs_ff, nxt_rxs;
	logic [3:0] rph_ff, nxt_rph;
	logic [2:0] rbit_ff, nxt_rbit;
	logic [7:0] rsh_ff, nxt_rsh;
	logic rdone;

	always_comb
	begin
		nxt_rxs = rxs_ff;
		nxt_rph = rph_ff;
		nxt_rbit = rbit_ff;
		nxt_rsh = rsh_ff;
		rdone = 1'b0;
		if (tick)
		begin
			unique case (rxs_ff)
			RX_IDLE:
				if (!rxd_i)
				begin
					nxt_rph = 4'h1;
					if (rph_ff == 4'h7)
					begin
						nxt_rph = 4'h0;
						nxt_rxs = RX_DATA;
						nxt_rbit = 3'h0;
					end
					else
						nxt_rph = 4'(rph_ff + 1'b1);
				end
				else
					nxt_rph = 4'h0;
			RX_DATA:
			begin
				nxt_rph = 4'(rph_ff + 1'b1);
				if (rph_ff == 4'hf)
				begin
					nxt_rsh = {rxd_i, rsh_ff[7:1]};
					nxt_rbit = 3'(rbit_ff + 1'b1);
					if (rbit_ff == 3'(DATA_BITS - 1))
						nxt_rxs = RX_STOP;
				end
			end
			RX_STOP:
			begin
				nxt_rph = 4'(rph_ff + 1'b1);
				if (rph_ff == 4'hf)
				begin
					nxt_rxs = RX_IDLE;
					nxt_rph = 4'h0;
					rdone = rxd_i; // framing error drops byte
				end
			end
			endcase
		end
	end

	// ----------------------------------------
	// Receive queue, lines and control chars
	// ----------------------------------------
	logic [7:0] q_ff [RX_DEPTH];
	logic [RXQ_AW-1:0] qw_ff, nxt_qw, qr_ff, nxt_qr;
	logic [RXQ_AW:0] qc_ff, nxt_qc;
	logic [RXQ_AW:0] lines_ff, nxt_lines;
	logic ctl_char, brk, push, pop;
	logic xoff_rx, xon_rx;

	always_comb
	begin
		brk = rdone && (rsh_ff == CH_CTRL_C || rsh_ff == CH_CTRL_X);
		xoff_rx = rdone && software_flow_option_i && rsh_ff == CH_XOFF;
		xon_rx = rdone && software_flow_option_i && rsh_ff == CH_XON;
		ctl_char = brk || xoff_rx || xon_rx;
		push = rdone && !ctl_char && qc_ff != 5'(RX_DEPTH);
		pop = cmd_valid_o && cmd_ready_i && !brk;
		nxt_qw = push ? 4'(qw_ff + 1'b1) : qw_ff;
		nxt_qr = pop ? 4'(qr_ff + 1'b1) : qr_ff;
		nxt_qc = 5'(qc_ff + {4'h0, push} - {4'h0, pop});
		nxt_lines = 5'(lines_ff + {4'h0, push && rsh_ff == CH_CR}
			- {4'h0, pop && q_ff[qr_ff] == CH_CR});
		if (brk)
		begin
			nxt_qw = '0;
			nxt_qr = '0;
			nxt_qc = '0;
			nxt_lines = '0;
		end
	end

	// ----------------------------------------
	// Flow control state
	// ----------------------------------------
	logic sent_xoff_ff, nxt_sent_xoff;
	logic want_xoff_ff, nxt_want_xoff, want_xon_ff, nxt_want_xon;
	logic paused_ff, nxt_paused;
	logic ctl_go;

	always_comb
	begin
		nxt_sent_xoff = sent_xoff_ff;
		nxt_want_xoff = want_xoff_ff;
		nxt_want_xon = want_xon_ff;
		nxt_paused = paused_ff;
		if (!software_flow_option_i)
		begin
			nxt_sent_xoff = 1'b0;
			nxt_want_xoff = 1'b0;
			nxt_want_xon = 1'b0;
			nxt_paused = 1'b0;
		end
		else
		begin
			// Clear only what goes out; a request set now must not be lost
			if (ctl_go && want_xoff_ff)
				nxt_want_xoff = 1'b0;
			else if (ctl_go)
				nxt_want_xon = 1'b0;
			if (!sent_xoff_ff && qc_ff > RXQ_HIGH)
			begin
				nxt_sent_xoff = 1'b1;
				nxt_want_xoff = 1'b1;
				nxt_want_xon = 1'b0;
			end
			if (sent_xoff_ff && qc_ff < RXQ_LOW)
			begin
				nxt_sent_xoff = 1'b0;
				nxt_want_xon = 1'b1;
			end
			if (xoff_rx)
				nxt_paused = 1'b1;
			else if (xon_rx)
				nxt_paused = 1'b0;
		end
	end

	// ----------------------------------------
	// Transmit path: buffer, terminator, shifter
	// ----------------------------------------
	typedef enum logic [3:0] {TX_IDLE = 4'b0001, TX_START = 4'b0010,
		TX_DATA = 4'b0100, TX_STOP = 4'b1000} srp_tx_e;
	srp_tx_e txs_ff, nxt_txs;
	logic [7:0] b_data;
	logic b_valid, b_ready, b_in_ready, b_in_valid;
	logic [7:0] b_in_data;
	logic [1:0] tpend_ff, nxt_tpend;
	logic [7:0] tsh_ff, nxt_tsh;
	logic [3:0] tph_ff, nxt_tph;
	logic [2:0] tbit_ff, nxt_tbit;
	logic txd_ff, nxt_txd;
	logic msg_take, command_language_setting_bad;

	srp_buf2 #(.W(8)) u_txbuf (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.flush_i(brk),
		.in_data_i(b_in_data),
		.in_valid_i(b_in_valid),
		.in_ready_o(b_in_ready),
		.out_data_o(b_data),
		.out_valid_o(b_valid),
		.out_ready_i(b_ready)
	);

	always_comb
	begin
		// Setting is held outside, so our reset never touches it
		command_language_setting_bad = (command_language_setting_i != COMMAND_LANGUAGE_SETTING_STANDARD);
		b_in_valid = 1'b0;
		b_in_data = msg_data_i;
		msg_take = 1'b0;
		nxt_tpend = tpend_ff;
		if (tpend_ff != 2'h0)
		begin
			b_in_valid = 1'b1;
			unique case (term_sel_i)
			TERM_LF: b_in_data = CH_LF;
			TERM_CR: b_in_data = CH_CR;
			TERM_CRLF: b_in_data = tpend_ff == 2'h2 ? CH_CR : CH_LF;
			TERM_LFCR: b_in_data = tpend_ff == 2'h2 ? CH_LF : CH_CR;
			endcase
			if (b_in_ready)
				nxt_tpend = 2'(tpend_ff - 1'b1);
		end
		else if (msg_valid_i && !command_language_setting_bad)
		begin
			b_in_valid = 1'b1;
			msg_take = b_in_ready;
			if (b_in_ready && msg_last_i)
				nxt_tpend = term_sel_i[1] ? 2'h2 : 2'h1;
		end
		if (brk)
			nxt_tpend = 2'h0;
	end

	always_comb
	begin
		nxt_txs = txs_ff;
		nxt_tsh = tsh_ff;
		nxt_tph = tph_ff;
		nxt_tbit = tbit_ff;
		nxt_txd = txd_ff;
		b_ready = 1'b0;
		ctl_go = 1'b0;
		unique case (txs_ff)
		TX_IDLE:
		begin
			nxt_txd = 1'b1;
			if (want_xoff_ff || want_xon_ff)
			begin
				ctl_go = 1'b1;
				nxt_tsh = want_xoff_ff ? CH_XOFF : CH_XON;
				nxt_txs = TX_START;
				nxt_tph = 4'h0;
			end
			else if (b_valid && !paused_ff && !brk)
			begin
				b_ready = 1'b1;
				nxt_tsh = b_data;
				nxt_txs = TX_START;
				nxt_tph = 4'h0;
			end
		end
		TX_START:
		begin
			nxt_txd = 1'b0;
			if (tick)
			begin
				nxt_tph = 4'(tph_ff + 1'b1);
				if (tph_ff == 4'hf)
				begin
					nxt_txs = TX_DATA;
					nxt_tbit = 3'h0;
				end
			end
		end
		TX_DATA:
		begin
			nxt_txd = tsh_ff[0];
			if (tick)
			begin
				nxt_tph = 4'(tph_ff + 1'b1);
				if (tph_ff == 4'hf)
				begin
					nxt_tsh = {1'b0, tsh_ff[7:1]};
					nxt_tbit = 3'(tbit_ff + 1'b1);
					if (tbit_ff == 3'(DATA_BITS - 1))
						nxt_txs = TX_STOP;
				end
			end
		end
		TX_STOP:
		begin
			nxt_txd = 1'b1;
			if (tick)
			begin
				nxt_tph = 4'(tph_ff + 1'b1);
				if (tph_ff == 4'hf)
					nxt_txs = TX_IDLE;
			end
		end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rate_ff <= RATE_RESET;
			tdiv_ff <= '0;
			rxs_ff <= RX_IDLE;
			rph_ff <= 4'h0;
			rbit_ff <= 3'h0;
			rsh_ff <= 8'h00;
			qw_ff <= '0;
			qr_ff <= '0;
			qc_ff <= '0;
			lines_ff <= '0;
			sent_xoff_ff <= 1'b0;
			want_xoff_ff <= 1'b0;
			want_xon_ff <= 1'b0;
			paused_ff <= 1'b0;
			txs_ff <= TX_IDLE;
			tpend_ff <= 2'h0;
			tsh_ff <= 8'h00;
			tph_ff <= 4'h0;
			tbit_ff <= 3'h0;
			txd_ff <= 1'b1;
			abort_o <= 1'b0;
			rx_overrun_o <= 1'b0;
			command_language_setting_reject_o <= 1'b0;
		end
		else
		begin
			rate_ff <= nxt_rate;
			tdiv_ff <= nxt_tdiv;
			rxs_ff <= nxt_rxs;
			rph_ff <= nxt_rph;
			rbit_ff <= nxt_rbit;
			rsh_ff <= nxt_rsh;
			qw_ff <= nxt_qw;
			qr_ff <= nxt_qr;
			qc_ff <= nxt_qc;
			lines_ff <= nxt_lines;
			sent_xoff_ff <= nxt_sent_xoff;
			want_xoff_ff <= nxt_want_xoff;
			want_xon_ff <= nxt_want_xon;
			paused_ff <= nxt_paused;
			txs_ff <= nxt_txs;
			tpend_ff <= nxt_tpend;
			tsh_ff <= nxt_tsh;
			tph_ff <= nxt_tph;
			tbit_ff <= nxt_tbit;
			txd_ff <= nxt_txd;
			abort_o <= brk;
			rx_overrun_o <= rdone && !ctl_char && qc_ff == 5'(RX_DEPTH);
			command_language_setting_reject_o <= command_language_setting_bad && msg_valid_i;
		end
	end

	// Queue storage has no reset; only written entries are ever read
	always_ff @(posedge clk_i)
	begin
		if (push)
			q_ff[qw_ff] <= rsh_ff;
	end

	// Queue head is a flop read; line gate keeps partial lines back
	assign txd_o = txd_ff;
	assign cmd_data_o = q_ff[qr_ff];
	assign cmd_valid_o = (qc_ff != '0) && (lines_ff != '0);
	assign cmd_line_o = (lines_ff != '0);
	assign msg_ready_o = msg_take;
	assign paused_o = paused_ff;
	assign rate_o = rate_ff;
endmodule
`default_nettype wire

// ---- tb/srp_top_properties.sv ----
/*
 Port checker for srp_top, bound to every instance.
 Assumes one clock domain with an async active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module srp_props
	import srp_pkg::*;
#(
	parameter int unsigned RX_DEPTH = 16
) (
	input wire logic clk_i, // Clock
	input wire logic reset_i, // Reset
	input wire logic [2:0] rate_sel_i, // Rate code
	input wire logic rate_load_i, // Rate load
	input wire logic [2:0] rate_o, // Active rate
	input wire logic abort_o, // Break pulse
	input wire logic cmd_valid_o, // Command byte valid
	input wire logic cmd_line_o, // Line queued
	input wire logic [7:0] cmd_data_o, // Command byte
	input wire logic cmd_ready_i, // Parser takes byte
	input wire logic msg_valid_i, // Message valid
	input wire logic msg_ready_o, // Message taken
	input wire logic command_language_setting_i, // Language
	input wire logic command_language_setting_reject_o, // Language flag
	input wire logic software_flow_option_i, // Flow option
	input wire logic paused_o, // Paused by host
	input wire logic txd_o // Serial out
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	property p_rate_load;
		rate_load_i && rate_sel_i != 3'h7 |=> rate_o == $past(rate_sel_i);
	endproperty
	a_rate_load: assert property (p_rate_load)
		else $error("Rate code not loaded");
	property p_rate_hold;
		!(rate_load_i && rate_sel_i != 3'h7) |=> $stable(rate_o);
	endproperty
	a_rate_hold: assert property (p_rate_hold)
		else $error("Rate changed without load");
	property p_abort_pulse;
		abort_o |=> !abort_o;
	endproperty
	a_abort_pulse: assert property (p_abort_pulse)
		else $error("Abort pulse too long");
	property p_abort_flush;
		abort_o |-> ##2 (!cmd_valid_o && !cmd_line_o);
	endproperty
	a_abort_flush: assert property (p_abort_flush)
		else $error("Queue kept after abort");
	property p_release;
		cmd_valid_o |-> cmd_line_o;
	endproperty
	a_release: assert property (p_release)
		else $error("Byte released without line end");
	property p_cmd_hold;
		cmd_valid_o && !cmd_ready_i |=> abort_o
			|| (cmd_valid_o && $stable(cmd_data_o));
	endproperty
	a_cmd_hold: assert property (p_cmd_hold)
		else $error("Command byte changed before taken");
	property p_command_language_setting_block;
		command_language_setting_i != COMMAND_LANGUAGE_SETTING_STANDARD |-> !msg_ready_o;
	endproperty
	a_command_language_setting_block: assert property (p_command_language_setting_block)
		else $error("Message taken with wrong language");
	property p_command_language_setting_flag;
		msg_valid_i && command_language_setting_i != COMMAND_LANGUAGE_SETTING_STANDARD
			|=> command_language_setting_reject_o;
	endproperty
	a_command_language_setting_flag: assert property (p_command_language_setting_flag)
		else $error("Language reject not flagged");
	property p_flow_off;
		!software_flow_option_i |=> !paused_o;
	endproperty
	a_flow_off: assert property (p_flow_off)
		else $error("Paused while flow control off");
	property p_start_bit;
		$fell(txd_o) |-> !txd_o [*8];
	endproperty
	a_start_bit: assert property (p_start_bit)
		else $error("Start bit too short");
	c_abort: cover property (abort_o);
	c_line: cover property ($rose(cmd_line_o));
	c_reject: cover property (command_language_setting_reject_o);
	c_pause: cover property ($rose(paused_o));
endmodule
bind srp_top srp_props #(.RX_DEPTH(RX_DEPTH)) u_props (.clk_i, .reset_i,
	.rate_sel_i, .rate_load_i, .rate_o, .abort_o, .cmd_valid_o, .cmd_line_o,
	.cmd_data_o, .cmd_ready_i,
	.msg_valid_i, .msg_ready_o, .command_language_setting_i, .command_language_setting_reject_o,
	.software_flow_option_i, .paused_o, .txd_o);
`default_nettype wire

// ---- tb/srp_host_model.sv ----
/*
 Host serial port model: sends 8N1 characters, collects received ones.
 Assumes the device runs at the bit time given by BIT_CYC.
*/
`timescale 1ns/100ps
`default_nettype none
module srp_host_model
	import srp_pkg::*;
#(
	parameter int BIT_CYC = 2080
) (
	input wire logic clk_i, // Clock
	input wire logic line_i, // Device transmit line
	output logic line_o // Host transmit line
);
	logic [7:0] rx_q [$];
	logic [7:0] got;
	logic host_paused = 1'b0;
	initial line_o = 1'b1;
	// Start low, LSB first, stop high; only data lines used
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		while (host_paused)
			@(negedge clk_i);
		for (int i = 0; i < 10; i++)
		begin
			line_o = frame[i];
			repeat (BIT_CYC) @(negedge clk_i);
		end
	endtask
	always
	begin
		@(negedge line_i);
		repeat (BIT_CYC / 2) @(posedge clk_i);
		for (int k = 0; k < 8; k++)
		begin
			repeat (BIT_CYC) @(posedge clk_i);
			got[k] = line_i;
		end
		repeat (BIT_CYC) @(posedge clk_i);
		// Bad stop bit: character dropped, bench sees short count
		if (line_i === 1'b1)
		begin
			rx_q.push_back(got);
			// Hold our own sending while the device asks for a pause
			if (got == CH_XOFF)
				host_paused = 1'b1;
			else if (got == CH_XON)
				host_paused = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- tb/srp_top_test.sv ----
/*
 Testbench for srp_top: rates, language block, line release, break,
 message terminator. Assumes srp_host_model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module srp_top_test;
	import srp_pkg::*;
	localparam int BIT = OVERSAMPLE * TICK_DIV_BASE;
	logic clk_i, reset_i, rxd_i, txd_o, rate_load_i, software_flow_option_i;
	logic command_language_setting_i, msg_last_i, msg_valid_i, msg_ready_o;
	logic cmd_valid_o, cmd_ready_i, cmd_line_o, abort_o, command_language_setting_reject_o;
	logic paused_o, rx_overrun_o;
	logic [2:0] rate_sel_i, rate_o;
	logic [1:0] term_sel_i;
	logic [7:0] msg_data_i, cmd_data_o;
	logic [7:0] exp_tx [2];
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	int n_abort = 0;
	int n_over = 0;
	srp_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .rxd_i(rxd_i),
		.txd_o(txd_o), .rate_sel_i(rate_sel_i), .rate_load_i(rate_load_i),
		.software_flow_option_i(software_flow_option_i),
		.term_sel_i(term_sel_i),
		.command_language_setting_i(command_language_setting_i),
		.msg_data_i(msg_data_i), .msg_last_i(msg_last_i),
		.msg_valid_i(msg_valid_i), .msg_ready_o(msg_ready_o),
		.cmd_data_o(cmd_data_o), .cmd_valid_o(cmd_valid_o),
		.cmd_ready_i(cmd_ready_i), .cmd_line_o(cmd_line_o),
		.abort_o(abort_o), .command_language_setting_reject_o(command_language_setting_reject_o),
		.paused_o(paused_o), .rx_overrun_o(rx_overrun_o), .rate_o(rate_o));
	srp_host_model #(.BIT_CYC(BIT)) u_host (.clk_i(clk_i), .line_i(txd_o),
		.line_o(rxd_i));
	always #12.5 clk_i = ~clk_i;
	task automatic report_and_stop();
		$display("Compares %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Run needs about 85300 cycles at the fastest rate
	always @(posedge clk_i)
	begin
		cyc++;
		if (abort_o === 1'b1)
			n_abort++;
		if (rx_overrun_o === 1'b1)
			n_over++;
		if (cyc == 95000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic load_rate(input logic [2:0] c);
		rate_sel_i = c;
		rate_load_i = 1'b1;
		@(negedge clk_i);
		rate_load_i = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic send_msg(input logic [7:0] d);
		int n;
		n = 0;
		msg_data_i = d;
		msg_last_i = 1'b1;
		msg_valid_i = 1'b1;
		// Ready is read at the edge that takes the byte
		@(posedge clk_i);
		while (msg_ready_o !== 1'b1 && n < 100)
		begin
			@(posedge clk_i);
			n++;
		end
		@(negedge clk_i);
		msg_valid_i = 1'b0;
		msg_last_i = 1'b0;
		if (n == 100)
			num_errors++;
	endtask
	initial
	begin
		clk_i = 1'b0;
		reset_i = 1'b1;
		rate_load_i = 1'b0;
		rate_sel_i = 3'h0;
		software_flow_option_i = 1'b0;
		term_sel_i = TERM_CRLF;
		command_language_setting_i = COMMAND_LANGUAGE_SETTING_STANDARD;
		msg_data_i = 8'h00;
		msg_last_i = 1'b0;
		msg_valid_i = 1'b0;
		cmd_ready_i = 1'b0;
		exp_tx = '{8'h42, CH_CR};
		repeat (5) @(negedge clk_i);
		reset_i = 1'b0;
		`CHK(txd_o, 1'b1)
		`CHK(rate_o, RATE_9600)
		for (int c = 6; c >= 0; c--)
		begin
			load_rate(3'(c));
			`CHK(rate_o, 3'(c))
		end
		load_rate(3'h7);
		`CHK(rate_o, RATE_19200)
		command_language_setting_i = 1'b1;
		msg_valid_i = 1'b1;
		@(negedge clk_i);
		@(negedge clk_i);
		`CHK(msg_ready_o, 1'b0)
		`CHK(command_language_setting_reject_o, 1'b1)
		msg_valid_i = 1'b0;
		command_language_setting_i = COMMAND_LANGUAGE_SETTING_STANDARD;
		software_flow_option_i = 1'b1;
		@(negedge clk_i);
		// Pause lands while CR is on the line: LF waits, then break drops it
		fork
			send_msg(8'h42);
			begin
				u_host.send_byte(8'h41);
				`CHK(cmd_line_o, 1'b0)
				u_host.send_byte(CH_XOFF);
				`CHK(paused_o, 1'b1)
				`CHK(cmd_valid_o, 1'b0)
				u_host.send_byte(CH_CTRL_C);
				`CHK(n_abort, 1)
				software_flow_option_i = 1'b0;
				@(negedge clk_i);
				`CHK(paused_o, 1'b0)
				u_host.send_byte(CH_CR);
				repeat (4) @(negedge clk_i);
				`CHK(cmd_line_o, 1'b1)
				`CHK(cmd_data_o, CH_CR)
				cmd_ready_i = 1'b1;
				@(negedge clk_i);
				cmd_ready_i = 1'b0;
				`CHK(cmd_valid_o, 1'b0)
			end
		join
		repeat (BIT) @(negedge clk_i);
		`CHK(u_host.rx_q.size(), 2)
		for (int i = 0; i < 2; i++)
			`CHK(u_host.rx_q[i], exp_tx[i])
		`CHK(n_over, 0)
		report_and_stop();
	end
endmodule
`default_nettype wire
